/* File: jtag_dbg_pkg.sv */
// package: constants for the test access port and debug reset block
// Overview of operation
// - one standard test access port on the chain, boundary scan of the pins
// - four-bit instruction register, thirty-two-bit data register
// - a path through this port reaches a chip port for the tile
// - test reset held low keeps the whole access module in reset
// - debug pin as output floats until breakpoint, then driven low
// - debug pin as input, external low forces the tile into debug
// - identification instruction selects the identification register for shifting
// - user code instruction selects the user code register for shifting
// - user field comes from security bits 22 to 31 of tile zero
// - global reset low enters reset at once, without a clock
// - after global reset release, wait for pll lock, then boot
// - security bit 0 disables the test access port entirely
// - security bit 14 blocks the debug pin both ways
package jtag_dbg_pkg;
    localparam int IR_W = 4;
    localparam int DR_W = 32;
    // instruction codes
    localparam logic [3:0] INS_EXTEST   = 4'h0;
    localparam logic [3:0] INS_SAMPLE   = 4'h1;
    localparam logic [3:0] INS_IDENT    = 4'h2;
    localparam logic [3:0] INS_USER     = 4'h3;
    localparam logic [3:0] INS_CHIP     = 4'h4;
    localparam logic [3:0] INS_BYPASS   = 4'hF;
    localparam logic [3:0] IR_CAPTURE   = 4'h1;
    // identification fields (values arbitrary)
    localparam logic [3:0]  ID_VERSION  = 4'h1;
    localparam logic [15:0] ID_PART     = 16'h1234;
    localparam logic [10:0] ID_MAKER    = 11'h155;
    // user code layout
    localparam int UC_USER_LSB = 22;
    localparam int UC_USER_W   = 10;
    localparam logic [7:0] UC_SI_REV = 8'h01;
    // security bit positions
    localparam int SEC_JTAG_OFF  = 0;
    localparam int SEC_DEBUG_OFF = 14;
    // reset hold time
    localparam int  RST_HOLD_NS  = 100;
    localparam int  CLK_NS       = 50;
    localparam int  RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [15:0] {
        TLR = 16'h0001, RTI = 16'h0002, SDS = 16'h0004, CDR = 16'h0008,
        SDR = 16'h0010, E1D = 16'h0020, PDR = 16'h0040, E2D = 16'h0080,
        UDR = 16'h0100, SIS = 16'h0200, CIR = 16'h0400, SIR = 16'h0800,
        E1I = 16'h1000, PIR = 16'h2000, E2I = 16'h4000, UIR = 16'h8000
    } tap_st_t;
    typedef enum logic [2:0] {
        B_RESET = 3'h1, B_WAIT = 3'h2, B_RUN = 3'h4
    } boot_st_t;
endpackage

/* File: jtag_tap_dbg.sv */
// module: test access port, debug pin and global reset sequencing
`timescale 1ns/1ps
module jtag_tap_dbg #(
    parameter int BSR_W = 8
) (
    // core clock and global reset
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_glob_rst_n,
    input  wire logic              i_pll_lock,
    // test port pins
    input  wire logic              i_tck,
    input  wire logic              i_tms,
    input  wire logic              i_tdi,
    input  wire logic              i_trst_n,
    output logic                   o_tdo,
    output logic                   o_tdo_oe,
    // security register of tile zero
    input  wire logic [31:0]       i_security,
    // boundary pins
    input  wire logic [BSR_W-1:0]  i_pin_in,
    output logic      [BSR_W-1:0]  o_pin_out,
    output logic                   o_extest,
    // chip port path
    output logic                   o_chip_sel,
    output logic                   o_chip_tdi,
    output logic                   o_chip_tms,
    output logic                   o_chip_tck,
    input  wire logic              i_chip_tdo,
    // debug pin and mode
    input  wire logic              i_debug_in,
    output logic                   o_debug_out,
    output logic                   o_debug_oe,
    input  wire logic              i_dbg_out_mode,
    input  wire logic              i_dbg_in_mode,
    input  wire logic              i_breakpoint,
    output logic                   o_force_debug,
    // reset and boot
    output logic                   o_core_rst_n,
    output logic                   o_boot_start
);
    // two-stage syncs: tck, tms, tdi, trst_n, debug pin, chip tdo
    logic [5:0] pin_s;
    logic       tck_d_ff;
    jtag_dbg_sync2 #(.W(6)) u_pin_sync (
        .i_clk   (i_core_clk),
        .i_async ({i_tck, i_tms, i_tdi, i_trst_n, i_debug_in, i_chip_tdo}),
        .o_sync  (pin_s)
    );
    // tck edges found in the core domain; tck must stay well below a third of it
    always_ff @(posedge i_core_clk) begin
        tck_d_ff <= pin_s[5];
    end
    // synced pin views, only the second flop is read
    logic tms_s, tdi_s, trst_s, dbg_s, ctdo_s, tck_rise, tck_fall;
    assign tms_s  = pin_s[4];
    assign tdi_s  = pin_s[3];
    assign trst_s = pin_s[2];
    assign dbg_s  = pin_s[1];
    assign ctdo_s = pin_s[0];
    assign tck_rise = pin_s[5] & ~tck_d_ff;
    assign tck_fall = ~pin_s[5] & tck_d_ff;

    // asynchronous entry
    // global reset asserts at once, releases through the core clock
    logic [1:0] grst_ff;
    always_ff @(posedge i_core_clk or negedge i_glob_rst_n) begin
        if (!i_glob_rst_n) begin
            grst_ff <= 2'h0;
        end else begin
            grst_ff <= {grst_ff[0], 1'b1};
        end
    end
    assign o_core_rst_n = grst_ff[1];

    logic [1:0] lock_ff;
    jtag_dbg_pkg::boot_st_t boot_ff;
    always_ff @(posedge i_core_clk or negedge i_glob_rst_n) begin
        if (!i_glob_rst_n) begin
            lock_ff <= 2'h0;
            boot_ff <= jtag_dbg_pkg::B_RESET;
        end else begin
            lock_ff <= {lock_ff[0], i_pll_lock};
            case (boot_ff)
                jtag_dbg_pkg::B_RESET: if (grst_ff[1]) boot_ff <= jtag_dbg_pkg::B_WAIT;
                jtag_dbg_pkg::B_WAIT:  if (lock_ff[1]) boot_ff <= jtag_dbg_pkg::B_RUN;
                jtag_dbg_pkg::B_RUN:   boot_ff <= jtag_dbg_pkg::B_RUN;
                default:               boot_ff <= jtag_dbg_pkg::B_RESET;
            endcase
        end
    end
    // boot start registered, so the boot logic sees one clean level
    always_ff @(posedge i_core_clk or negedge i_glob_rst_n) begin
        if (!i_glob_rst_n) begin
            o_boot_start <= 1'b0;
        end else begin
            o_boot_start <= (boot_ff == jtag_dbg_pkg::B_RUN);
        end
    end

    // test reset and security disable hold the port in reset
    logic tap_hold;
    assign tap_hold = ~trst_s | i_security[jtag_dbg_pkg::SEC_JTAG_OFF] | ~i_rst_n;

    // standard tap controller stepped on tck rising edge
    jtag_dbg_pkg::tap_st_t st_ff, nxt_st;
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            jtag_dbg_pkg::TLR: nxt_st = tms_s ? jtag_dbg_pkg::TLR : jtag_dbg_pkg::RTI;
            jtag_dbg_pkg::RTI: nxt_st = tms_s ? jtag_dbg_pkg::SDS : jtag_dbg_pkg::RTI;
            jtag_dbg_pkg::SDS: nxt_st = tms_s ? jtag_dbg_pkg::SIS : jtag_dbg_pkg::CDR;
            jtag_dbg_pkg::CDR: nxt_st = tms_s ? jtag_dbg_pkg::E1D : jtag_dbg_pkg::SDR;
            jtag_dbg_pkg::SDR: nxt_st = tms_s ? jtag_dbg_pkg::E1D : jtag_dbg_pkg::SDR;
            jtag_dbg_pkg::E1D: nxt_st = tms_s ? jtag_dbg_pkg::UDR : jtag_dbg_pkg::PDR;
            jtag_dbg_pkg::PDR: nxt_st = tms_s ? jtag_dbg_pkg::E2D : jtag_dbg_pkg::PDR;
            jtag_dbg_pkg::E2D: nxt_st = tms_s ? jtag_dbg_pkg::UDR : jtag_dbg_pkg::SDR;
            jtag_dbg_pkg::UDR: nxt_st = tms_s ? jtag_dbg_pkg::SDS : jtag_dbg_pkg::RTI;
            jtag_dbg_pkg::SIS: nxt_st = tms_s ? jtag_dbg_pkg::TLR : jtag_dbg_pkg::CIR;
            jtag_dbg_pkg::CIR: nxt_st = tms_s ? jtag_dbg_pkg::E1I : jtag_dbg_pkg::SIR;
            jtag_dbg_pkg::SIR: nxt_st = tms_s ? jtag_dbg_pkg::E1I : jtag_dbg_pkg::SIR;
            jtag_dbg_pkg::E1I: nxt_st = tms_s ? jtag_dbg_pkg::UIR : jtag_dbg_pkg::PIR;
            jtag_dbg_pkg::PIR: nxt_st = tms_s ? jtag_dbg_pkg::E2I : jtag_dbg_pkg::PIR;
            jtag_dbg_pkg::E2I: nxt_st = tms_s ? jtag_dbg_pkg::UIR : jtag_dbg_pkg::SIR;
            jtag_dbg_pkg::UIR: nxt_st = tms_s ? jtag_dbg_pkg::SDS : jtag_dbg_pkg::RTI;
            default:           nxt_st = jtag_dbg_pkg::TLR;
        endcase
    end
    always_ff @(posedge i_core_clk) begin
        if (tap_hold) begin
            st_ff <= jtag_dbg_pkg::TLR;
        end else if (tck_rise) begin
            st_ff <= nxt_st;
        end
    end

    logic [jtag_dbg_pkg::IR_W-1:0] ir_sh_ff, ir_ff;
    always_ff @(posedge i_core_clk) begin
        if (tap_hold) begin
            ir_sh_ff <= jtag_dbg_pkg::IR_CAPTURE;
            ir_ff    <= jtag_dbg_pkg::INS_IDENT;
        end else if (tck_rise) begin
            case (st_ff)
                jtag_dbg_pkg::TLR: ir_ff <= jtag_dbg_pkg::INS_IDENT;
                jtag_dbg_pkg::CIR: ir_sh_ff <= jtag_dbg_pkg::IR_CAPTURE;
                jtag_dbg_pkg::SIR: ir_sh_ff <= {tdi_s, ir_sh_ff[jtag_dbg_pkg::IR_W-1:1]};
                jtag_dbg_pkg::UIR: ir_ff <= ir_sh_ff;
                default: ;
            endcase
        end
    end

    logic [31:0] id_word, uc_word;
    assign id_word = {jtag_dbg_pkg::ID_VERSION, jtag_dbg_pkg::ID_PART,
                      jtag_dbg_pkg::ID_MAKER, 1'b1};
    // user field from security bits 22..31
    assign uc_word = {i_security[jtag_dbg_pkg::UC_USER_LSB +: jtag_dbg_pkg::UC_USER_W],
                      14'h0000, jtag_dbg_pkg::UC_SI_REV};

    // thirty-two-bit data shift, capture per instruction
    logic [jtag_dbg_pkg::DR_W-1:0] dr_ff;
    logic [BSR_W-1:0]              bsr_upd_ff;
    logic                          byp_ff;
    always_ff @(posedge i_core_clk) begin
        if (tap_hold) begin
            dr_ff      <= '0;
            bsr_upd_ff <= '0;
            byp_ff     <= 1'b0;
        end else if (tck_rise) begin
            case (st_ff)
                jtag_dbg_pkg::CDR: begin
                    byp_ff <= 1'b0;
                    case (ir_ff)
                        jtag_dbg_pkg::INS_IDENT:  dr_ff <= id_word;
                        jtag_dbg_pkg::INS_USER:   dr_ff <= uc_word;
                        jtag_dbg_pkg::INS_EXTEST,
                        jtag_dbg_pkg::INS_SAMPLE: dr_ff <= {{(32-BSR_W){1'b0}}, i_pin_in};
                        default:                  dr_ff <= '0;
                    endcase
                end
                jtag_dbg_pkg::SDR: begin
                    dr_ff  <= {tdi_s, dr_ff[jtag_dbg_pkg::DR_W-1:1]};
                    byp_ff <= tdi_s;
                end
                jtag_dbg_pkg::UDR: begin
                    if (ir_ff == jtag_dbg_pkg::INS_EXTEST ||
                        ir_ff == jtag_dbg_pkg::INS_SAMPLE) begin
                        bsr_upd_ff <= dr_ff[BSR_W-1:0];
                    end
                end
                default: ;
            endcase
        end
    end
    assign o_pin_out = bsr_upd_ff;

    // extest flag and chip port path while selected
    // registered so no decode glitch reaches the pins; costs one core clock of lag
    logic sel_chip;
    assign sel_chip = (ir_ff == jtag_dbg_pkg::INS_CHIP);
    always_ff @(posedge i_core_clk) begin
        if (tap_hold) begin
            o_extest   <= 1'b0;
            o_chip_sel <= 1'b0;
            o_chip_tdi <= 1'b0;
            o_chip_tms <= 1'b0;
            o_chip_tck <= 1'b0;
        end else begin
            o_extest   <= (ir_ff == jtag_dbg_pkg::INS_EXTEST);
            o_chip_sel <= sel_chip;
            o_chip_tdi <= sel_chip & tdi_s;
            o_chip_tms <= sel_chip & tms_s;
            o_chip_tck <= sel_chip & pin_s[5];
        end
    end

    // tdo changes on tck falling edge, driven only while shifting
    logic tdo_ff, tdo_oe_ff, tdo_bit;
    always_comb begin
        tdo_bit = dr_ff[0];
        if (st_ff == jtag_dbg_pkg::SIR) begin
            tdo_bit = ir_sh_ff[0];
        end else if (ir_ff == jtag_dbg_pkg::INS_CHIP) begin
            tdo_bit = ctdo_s;
        end else if (ir_ff == jtag_dbg_pkg::INS_BYPASS) begin
            tdo_bit = byp_ff;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (tap_hold) begin
            tdo_ff    <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else if (tck_fall) begin
            tdo_ff    <= tdo_bit;
            tdo_oe_ff <= (st_ff == jtag_dbg_pkg::SDR) | (st_ff == jtag_dbg_pkg::SIR);
        end
    end
    assign o_tdo    = tdo_ff;
    assign o_tdo_oe = tdo_oe_ff;

    logic dbg_block;
    assign dbg_block = i_security[jtag_dbg_pkg::SEC_DEBUG_OFF];
    // float until breakpoint, then drive low; held until reset
    logic bp_ff;
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n || !grst_ff[1]) begin
            bp_ff <= 1'b0;
        end else if (i_breakpoint) begin
            bp_ff <= 1'b1;
        end
    end
    // pin only ever pulled low; the external pull-up gives the high level
    assign o_debug_out = 1'b0;
    // drive enable after breakpoint, gated by the block bit
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_debug_oe <= 1'b0;
        end else begin
            o_debug_oe <= i_dbg_out_mode & bp_ff & ~dbg_block;
        end
    end
    // external low forces debug mode, one clock after the synced pin
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_force_debug <= 1'b0;
        end else begin
            o_force_debug <= i_dbg_in_mode & ~dbg_s & ~dbg_block;
        end
    end
endmodule // jtag_tap_dbg

// two-flop synchroniser for signals from another clock domain
module jtag_dbg_sync2 #(
    parameter int W = 1
) (
    // clock
    input  wire logic          i_clk,
    // asynchronous inputs and synchronised copies
    input  wire logic [W-1:0]  i_async,
    output logic      [W-1:0]  o_sync
);
    // first stage may go metastable, so only the second is read outside
    logic [W-1:0] meta_ff, sync_ff;
    always_ff @(posedge i_clk) begin
        meta_ff <= i_async;
        sync_ff <= meta_ff;
    end
    assign o_sync = sync_ff;
endmodule // jtag_dbg_sync2

/* File: jtag_tap_dbg_chk.sv */
// checker: port-level properties of the test port and debug reset block
`timescale 1ns/1ps
module jtag_tap_dbg_chk (
    // clock and resets
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic        i_glob_rst_n,
    input wire logic        i_pll_lock,
    input wire logic        i_trst_n,
    input wire logic [31:0] i_security,
    // debug pin controls
    input wire logic        i_dbg_out_mode,
    input wire logic        i_dbg_in_mode,
    // watched outputs
    input wire logic        o_tdo_oe,
    input wire logic        o_debug_oe,
    input wire logic        o_debug_out,
    input wire logic        o_force_debug,
    input wire logic        o_core_rst_n,
    input wire logic        o_boot_start
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    a_glob_rst_now: assert property (!i_glob_rst_n |-> !o_core_rst_n)
        else $error("core reset not low during global reset");
    a_core_rst_rel: assert property ($rose(i_glob_rst_n) |-> ##[1:3] o_core_rst_n)
        else $error("core reset not released");
    // lock passes two sync flops, the boot state and the output register
    a_boot_after_lock: assert property ($rose(o_boot_start) |-> $past(i_pll_lock, 4))
        else $error("boot began without pll lock");
    // settle time covers the two sync flops and the output register
    a_trst_holds_off: assert property (!i_trst_n [*6] |-> !o_tdo_oe)
        else $error("test port active under test reset");
    a_secure_port_off: assert property (i_security[0] [*6] |-> !o_tdo_oe)
        else $error("test port active while disabled");
    a_dbg_out_gate: assert property (o_debug_oe |->
        $past(i_dbg_out_mode) && !$past(i_security[14]))
        else $error("debug pin driven while not allowed");
    a_dbg_drive_low: assert property (o_debug_oe |-> !o_debug_out)
        else $error("debug pin driven high");
    a_dbg_in_gate: assert property (o_force_debug |->
        $past(i_dbg_in_mode) && !$past(i_security[14]))
        else $error("debug forced while not allowed");
    c_boot: cover property ($rose(o_boot_start));
    c_dbg_out: cover property (o_debug_oe);
    c_dbg_in: cover property (o_force_debug);
endmodule // jtag_tap_dbg_chk
bind jtag_tap_dbg jtag_tap_dbg_chk u_chk (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_glob_rst_n(i_glob_rst_n),
    .i_pll_lock(i_pll_lock), .i_trst_n(i_trst_n), .i_security(i_security),
    .i_dbg_out_mode(i_dbg_out_mode), .i_dbg_in_mode(i_dbg_in_mode), .o_tdo_oe(o_tdo_oe),
    .o_debug_oe(o_debug_oe), .o_debug_out(o_debug_out), .o_force_debug(o_force_debug),
    .o_core_rst_n(o_core_rst_n), .o_boot_start(o_boot_start)
);

/* File: jtag_probe.sv */
// partner: behavioural debug probe driving the test port pins
`timescale 1ns/1ps
module jtag_probe (
    // test port pins
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    output logic      o_trst_n,
    input wire logic  i_tdo
);
    // test reset low past power up
    initial begin
        o_tck = 1'h0;
        o_tms = 1'h1;
        o_tdi = 1'h0;
        o_trst_n = 1'h0;
        #300 o_trst_n = 1'h1;
    end
    // one 400 ns tck period, tdo taken just before the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #200;
        tdo = i_tdo;
        o_tck = 1'h1;
        #200;
        o_tck = 1'h0;
    endtask
    // far side parks the port by pulling test reset low
    task automatic set_trst(input logic v);
        o_trst_n = v;
    endtask
    // shift n bits lsb first, idle to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic t;
        step(1'h1, 1'h0, t);
        if (ir) step(1'h1, 1'h0, t);
        step(1'h0, 1'h0, t);
        step(1'h0, 1'h0, t);
        dout = '0;
        for (int k = 0; k < n; k++) begin
            step(k == n - 1, din[k], t);
            dout[k] = t;
        end
        step(1'h1, 1'h0, t);
        step(1'h0, 1'h0, t);
    endtask
    // five ones reach test-logic-reset from any state, then idle
    task automatic idle();
        logic t;
        for (int k = 0; k < 5; k++) step(1'h1, 1'h0, t);
        step(1'h0, 1'h0, t);
    endtask
endmodule // jtag_probe

/* File: jtag_tap_and_debug_reset_tb_top.sv */
// testbench: scenarios for the test port, debug pin and reset sequencing
`timescale 1ns/1ps
module jtag_tap_and_debug_reset_tb_top;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0, glob_n = 1'h0, lock = 1'h1, brk = 1'h0;
    logic        out_md = 1'h0, in_md = 1'h0, ext_low = 1'h0, chip_tdo = 1'h0;
    logic [31:0] sec = 32'h0;
    logic [7:0]  pin_out;
    logic        tck, tms, tdi, trst_n, tdo, tdo_oe, dbg_pin, dbg_oe, dbg_out;
    logic        chip_sel, extest, force_dbg, core_rst_n, boot;
    int          n_errors = 0, tests_run = 0, oe_cnt = 0;
    always #25 clk = ~clk;
    // pin has a pull-up, so released reads high
    assign dbg_pin = dbg_oe ? dbg_out : !ext_low;
    // counts cycles with tdo driven; scenarios compare before and after
    always @(posedge clk) if (tdo_oe === 1'h1) oe_cnt <= oe_cnt + 1;
    jtag_probe probe (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n), .i_tdo(tdo));
    jtag_tap_dbg #(.BSR_W(8)) dut (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_glob_rst_n(glob_n), .i_pll_lock(lock),
        .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo),
        .o_tdo_oe(tdo_oe), .i_security(sec), .i_pin_in(8'hA5), .o_pin_out(pin_out),
        .o_extest(extest), .o_chip_sel(chip_sel), .o_chip_tdi(), .o_chip_tms(),
        .o_chip_tck(), .i_chip_tdo(chip_tdo), .i_debug_in(dbg_pin), .o_debug_out(dbg_out),
        .o_debug_oe(dbg_oe), .i_dbg_out_mode(out_md), .i_dbg_in_mode(in_md),
        .i_breakpoint(brk), .o_force_debug(force_dbg), .o_core_rst_n(core_rst_n),
        .o_boot_start(boot)
    );
    task automatic check(input string name, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic waitc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic ir(input logic [3:0] c, output logic [31:0] d);
        probe.scan(1'h1, 4, {28'h0, c}, d);
    endtask
    task automatic t_ident();
        logic [31:0] d;
        int          c0;
        c0 = oe_cnt;
        probe.idle();
        ir(jtag_dbg_pkg::INS_IDENT, d);
        check("ir capture", d, {28'h0, jtag_dbg_pkg::IR_CAPTURE});
        probe.scan(1'h0, 32, 32'h0, d);
        check("ident", d, {jtag_dbg_pkg::ID_VERSION, jtag_dbg_pkg::ID_PART,
                           jtag_dbg_pkg::ID_MAKER, 1'h1});
        check("oe in shift", oe_cnt != c0, 1'h1);
        // one-bit bypass: data comes back one place later, first bit zero
        ir(jtag_dbg_pkg::INS_BYPASS, d);
        probe.scan(1'h0, 32, 32'h3, d);
        check("bypass", d, 32'h6);
    endtask
    task automatic t_user_chip();
        logic [31:0] d;
        sec = 32'hB5400000;
        ir(jtag_dbg_pkg::INS_USER, d);
        probe.scan(1'h0, 32, 32'h0, d);
        check("user code", d, {10'h2D5, 14'h0, jtag_dbg_pkg::UC_SI_REV});
        ir(jtag_dbg_pkg::INS_CHIP, d);
        check("chip select", chip_sel, 1'h1);
        chip_tdo = 1'h1;
        probe.scan(1'h0, 32, 32'h0, d);
        check("chip tdo", d, 32'hFFFFFFFF);
        chip_tdo = 1'h0;
        ir(jtag_dbg_pkg::INS_EXTEST, d);
        check("extest", {chip_sel, extest}, 2'h1);
        probe.scan(1'h0, 32, 32'h3C, d);
        check("pin sample", d, 32'hA5);
        check("pin drive", pin_out, 8'h3C);
    endtask
    task automatic t_locked();
        logic [31:0] d;
        int          c0;
        sec = 32'h1;
        c0 = oe_cnt;
        ir(jtag_dbg_pkg::INS_USER, d);
        check("oe secured", oe_cnt - c0, 0);
        check("secured ir", d, 32'h0);
        sec = 32'h0;
        probe.set_trst(1'h0);
        waitc(8);
        c0 = oe_cnt;
        ir(jtag_dbg_pkg::INS_USER, d);
        check("oe test reset", oe_cnt - c0, 0);
        check("test reset ir", d, 32'h0);
        probe.set_trst(1'h1);
    endtask
    task automatic t_debug();
        out_md = 1'h1;
        waitc(6);
        check("pin floats", {dbg_oe, dbg_pin}, 2'h1);
        brk = 1'h1;
        waitc(6);
        check("pin low", {dbg_oe, dbg_pin}, 2'h2);
        rst_n = 1'h0;
        sec = 32'h4000;
        ext_low = 1'h1;
        in_md = 1'h1;
        waitc(3);
        rst_n = 1'h1;
        waitc(6);
        check("blocked", {dbg_oe, force_dbg}, 2'h0);
        // own drive off, so only the external low can force
        sec = 32'h0;
        out_md = 1'h0;
        waitc(6);
        check("forced", {dbg_oe, force_dbg}, 2'h1);
        ext_low = 1'h0;
        waitc(6);
        check("released", force_dbg, 1'h0);
        rst_n = 1'h0;
        waitc(3);
        {brk, out_md, in_md, ext_low} = 4'h0;
        rst_n = 1'h1;
    endtask
    task automatic t_glob();
        int k;
        glob_n = 1'h0;
        #5 check("async reset", core_rst_n, 1'h0);
        lock = 1'h0;
        // low hold; supplies taken as good long before release
        waitc(jtag_dbg_pkg::RST_HOLD_CYC + 1);
        glob_n = 1'h1;
        waitc(10);
        check("held for lock", {core_rst_n, boot}, 2'h2);
        lock = 1'h1;
        for (k = 0; k < 20 && boot !== 1'h1; k++) @(negedge clk);
        check("boot after lock", boot, 1'h1);
    endtask
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        waitc(3);
        rst_n = 1'h1;
        glob_n = 1'h1;
        waitc(4);
        t_ident();
        t_user_chip();
        t_locked();
        t_debug();
        t_glob();
        final_report();
    end
endmodule // jtag_tap_and_debug_reset_tb_top
